// ==== cssq_pkg.sv ====
// Package for the cell scan timing sequencer: scan kinds, states, timing.
// Assumes a 250 MHz mclk; all timing counts derive from it.
package cssq_pkg;

   localparam int CLK_MHZ      = 250;
   // One microsecond tick divider
   localparam int US_CYC       = CLK_MHZ;
   localparam int NUM_CELLS    = 14;

   // Cell mux scan offsets (us)
   localparam int MUX_CELL1_US   = 13;
   localparam int MUX_CELL2_US   = 40;
   localparam int MUX_CELL14_US  = 295;
   localparam int MUX_TEST_US    = 343;
   localparam int MUX_PHASE_US   = 378;
   localparam int MUX_ITER_US    = 875;
   localparam int MUX_REPEATS    = 8;
   localparam int MUX_END_US     = 6905;
   // Cell step spacing giving 40..295 over 12 steps
   localparam int CELL_STEP_NUM  = MUX_CELL14_US - MUX_CELL2_US;
   localparam int CELL_STEP_DEN  = NUM_CELLS - 2;

   // Voltage scan totals and per-cell cost; temp and scan-all totals
   localparam int VOLT_14_US     = 589;
   localparam int VOLT_4_US      = 376;
   localparam int VOLT_PER_CELL_X10 = ((VOLT_14_US - VOLT_4_US) * 10) / 10;
   localparam int TEMP_SCAN_US   = 3446;
   localparam int ALL_14_US      = 4496;
   // Wire scan and post-volt extra in scan-all, 14 cells
   localparam int WIRE_14_US     = 3367;
   localparam int WIRE_PER_CELL_X10 = 425;
   localparam int ALL_PER_CELL_X10  = 664;
   localparam int MUX_PER_CELL_X10  = 1700;

   // Averaging
   localparam int AVG_GAP_US     = 50;
   localparam int ADC_HIGH_US    = 330;
   localparam int ADC_LOW_US     = 300;
   localparam logic [2:0] CAV_MAX = 3'h5;

   typedef enum logic [2:0] {
      CSSQ_SCAN_VOLT = 3'h0,
      CSSQ_SCAN_TEMP = 3'h1,
      CSSQ_SCAN_WIRE = 3'h2,
      CSSQ_SCAN_ALL  = 3'h3,
      CSSQ_SCAN_MUX  = 3'h4
   } cssq_kind_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RUN  = 4'b0010,
      ST_GAP  = 4'b0100,
      ST_DONE = 4'b1000
   } cssq_state_t;

   typedef struct packed {
      logic       mode;
      logic       func;
      logic       option;
   } cssq_gpio2_cfg_t;

endpackage : cssq_pkg

// ==== cssq_sequencer.sv ====
// Cell scan timing sequencer: times scans, averaging passes and mux test.
// Assumes start comes from command logic on mclk; analog side samples on
// cell_sample_pulse with cell_index.
// How it works
// - Mux scan samples cells 1-14 at offsets
// - Mux test 343, phase 378, iteration 875
// - Repeat items 2-17 eight times, end 6905
// - Scan time grows with cell count, temp fixed
// - Scan-all covers volt, temp, wire scans
// - Every scan includes pack, temp, checks
// - Average code selects 1..32 passes
// - 50 us gap between averaging passes
// - Averaged 14-cell totals 588.5 to 20056.5; code gives 589 to 20398
// - GPIO2 shows ADC when all bits set; code drives it in voltage scans only
// - GPIO2 high 330 us per pass
// - GPIO2 low 300 us between passes; code gives pass length minus 330 plus the 50 us gap, 309 us at 14 cells
// - Masked cells skipped, scan ends earlier
`timescale 1ns/1ns
module cssq_sequencer
   import cssq_pkg::*;
#(
   parameter int US_CYCLES = US_CYC
) (
   input  wire logic            mclk,
   input  wire logic            sys_rst,
   input  wire logic            start,
   input  wire cssq_kind_t      scan_kind,
   input  wire logic [13:0]     cell_enable,
   input  wire logic [2:0]      cell_average_count,
   input  wire cssq_gpio2_cfg_t gpio2_cfg,
   output logic                 busy,
   output logic                 done,
   output logic                 cell_sample_pulse,
   output logic [3:0]           cell_index,
   output logic                 aux_sample_pulse,
   output logic                 mux_test_active,
   output logic                 mux_test_phase_select,
   output logic [2:0]           pass_count_q,
   output logic                 gpio2_out,
   output logic                 gpio2_oe
);

   cssq_state_t state_q;
   logic [15:0] us_q;        // us within current pass/gap
   logic [15:0] end_us_q;    // pass length
   logic [7:0]  div_q;
   logic        tick;
   logic [5:0]  passes_q;    // passes to run
   logic [5:0]  pass_q;
   logic [3:0]  iter_q;
   logic [3:0]  ncell;
   logic [15:0] cell_off [NUM_CELLS];
   logic [15:0] len_us;

   assign tick = (div_q == 8'(US_CYCLES - 1));

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= 8'h00;
      end else if (state_q == ST_IDLE || tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Connected cell count
   always_comb begin
      ncell = 4'h0;
      for (int i = 0; i < NUM_CELLS; i++) begin
         ncell = ncell + 4'(cell_enable[i]);
      end
   end

   // Cell sample offsets, cell 1 at 13, then 40 + k*255/12
   generate
      for (genvar g = 0; g < NUM_CELLS; g++) begin : g_off
         if (g == 0) begin : g_first
            assign cell_off[g] = 16'(MUX_CELL1_US);
         end else begin : g_rest
            assign cell_off[g] = 16'(MUX_CELL2_US +
               ((g - 1) * CELL_STEP_NUM) / CELL_STEP_DEN);
         end
      end
   endgenerate

   // Pass length per kind, linear in cells except fixed temp (in us)
   always_comb begin
      unique case (scan_kind)
         CSSQ_SCAN_VOLT: len_us = 16'(VOLT_14_US -
            ((14 - int'(ncell)) * VOLT_PER_CELL_X10 + 5) / 10);
         CSSQ_SCAN_TEMP: len_us = 16'(TEMP_SCAN_US);
         CSSQ_SCAN_WIRE: len_us = 16'(WIRE_14_US -
            ((14 - int'(ncell)) * WIRE_PER_CELL_X10) / 10);
         CSSQ_SCAN_ALL:  len_us = 16'(ALL_14_US -
            ((14 - int'(ncell)) * ALL_PER_CELL_X10) / 10);
         CSSQ_SCAN_MUX:  len_us = 16'(MUX_END_US -
            ((14 - int'(ncell)) * MUX_PER_CELL_X10) / 10);
         default:        len_us = 16'(VOLT_14_US);
      endcase
   end

   // Sequencer state
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q  <= ST_IDLE;
         us_q     <= 16'h0000;
         end_us_q <= 16'h0000;
         passes_q <= 6'h01;
         pass_q   <= 6'h00;
      end else begin
         unique case (state_q)
            ST_IDLE: if (start) begin
               state_q  <= ST_RUN;
               us_q     <= 16'h0000;
               end_us_q <= len_us;
               pass_q   <= 6'h00;
               // Averaging only on voltage scans
               passes_q <= (scan_kind == CSSQ_SCAN_VOLT &&
                  cell_average_count <= CAV_MAX) ?
                  6'(6'h01 << cell_average_count) : 6'h01;
            end
            ST_RUN: if (tick) begin
               if (us_q == end_us_q - 16'h0001) begin
                  us_q <= 16'h0000;
                  if (pass_q == passes_q - 6'h01) begin
                     state_q <= ST_DONE;
                  end else begin
                     state_q <= ST_GAP;
                     pass_q  <= pass_q + 6'h01;
                  end
               end else begin
                  us_q <= us_q + 16'h0001;
               end
            end
            ST_GAP: if (tick) begin
               if (us_q == 16'(AVG_GAP_US - 1)) begin
                  us_q    <= 16'h0000;
                  state_q <= ST_RUN;
               end else begin
                  us_q <= us_q + 16'h0001;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign busy = (state_q != ST_IDLE);
   assign done = (state_q == ST_DONE);

   // Mux scan iteration clock: first pass 875, repeats of items 2..17
   logic [15:0] it_us;
   always_comb begin
      it_us = us_q;
      if (scan_kind == CSSQ_SCAN_MUX && us_q >= 16'(MUX_ITER_US)) begin
         it_us = 16'(MUX_CELL2_US) + 16'((int'(us_q) - MUX_ITER_US) %
            (MUX_ITER_US - MUX_CELL2_US));
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         iter_q <= 4'h0;
      end else if (state_q == ST_IDLE) begin
         iter_q <= 4'h0;
      end else if (tick && state_q == ST_RUN &&
                   scan_kind == CSSQ_SCAN_MUX &&
                   it_us == 16'(MUX_ITER_US - 1) &&
                   iter_q != 4'(MUX_REPEATS)) begin
         iter_q <= iter_q + 4'h1;
      end
   end

   // Sample strobes, mux test window and phase select
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cell_sample_pulse     <= 1'b0;
         cell_index            <= 4'h0;
         aux_sample_pulse      <= 1'b0;
         mux_test_active       <= 1'b0;
         mux_test_phase_select <= 1'b1;
      end else begin
         cell_sample_pulse <= 1'b0;
         aux_sample_pulse  <= 1'b0;
         if (state_q == ST_RUN && tick) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
               if (it_us == cell_off[i] && cell_enable[i] &&
                   scan_kind != CSSQ_SCAN_TEMP) begin
                  cell_sample_pulse <= 1'b1;
                  cell_index        <= 4'(i);
               end
            end
            // Pack, internal temperature and checks
            if (us_q == end_us_q - 16'(MUX_TEST_US - MUX_CELL14_US)) begin
               aux_sample_pulse <= 1'b1;
            end
         end
         mux_test_active <= state_q == ST_RUN &&
            scan_kind == CSSQ_SCAN_MUX &&
            it_us >= 16'(MUX_TEST_US) && it_us < 16'(MUX_ITER_US);
         mux_test_phase_select <= !(state_q == ST_RUN &&
            scan_kind == CSSQ_SCAN_MUX &&
            it_us >= 16'(MUX_PHASE_US) && it_us < 16'(MUX_ITER_US));
      end
   end

   // ADC activity: high for the conversion, low for overhead
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio2_out <= 1'b0;
         gpio2_oe  <= 1'b0;
      end else begin
         gpio2_oe  <= gpio2_cfg.mode && gpio2_cfg.func &&
                      gpio2_cfg.option;
         gpio2_out <= gpio2_cfg.mode && gpio2_cfg.func &&
            gpio2_cfg.option && state_q == ST_RUN &&
            scan_kind == CSSQ_SCAN_VOLT &&
            us_q < 16'(ADC_HIGH_US);
      end
   end
   assign pass_count_q = 3'(pass_q);

   AST_DONE_ONE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      done |=> !done && !busy)
      else $error("done not a single pulse");
   AST_GAP_LEN: assert property (
      @(posedge mclk) disable iff (sys_rst)
      $rose(state_q == ST_GAP) |-> (state_q == ST_GAP) [*8])
      else $error("gap ended early");
   AST_TEMP_NOCELL: assert property (
      @(posedge mclk) disable iff (sys_rst)
      busy && scan_kind == CSSQ_SCAN_TEMP |=> !cell_sample_pulse)
      else $error("cell sampled in temp scan");
   AST_MASKED: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cell_sample_pulse |-> cell_enable[cell_index])
      else $error("masked cell sampled");
   AST_GPIO_OFF: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(gpio2_cfg.mode && gpio2_cfg.func && gpio2_cfg.option)
      |=> !gpio2_out)
      else $error("gpio2 active while not selected");
   AST_GPIO_GAP: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_q == ST_GAP |=> !gpio2_out)
      else $error("gpio2 high during gap");
   AST_PHASE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !mux_test_phase_select |-> mux_test_active)
      else $error("phase select outside mux test");
   AST_PASSES: assert property (
      @(posedge mclk) disable iff (sys_rst)
      busy && scan_kind != CSSQ_SCAN_VOLT |-> pass_q == 6'h00)
      else $error("averaging outside voltage scan");
   AST_ITER: assert property (
      @(posedge mclk) disable iff (sys_rst)
      done && scan_kind == CSSQ_SCAN_MUX && cell_enable == 14'h3fff
      |-> iter_q == 4'(MUX_REPEATS))
      else $error("mux iteration count wrong at end");

endmodule : cssq_sequencer

// ==== cssq_cell_model.sv ====
// Stand-in for the analog cell mux and ADC: counts cell samples.
// Assumes sample pulses arrive on mclk; clr starts a new scan.
`timescale 1ns/1ns
module cssq_cell_model (
   input  wire logic       mclk,
   input  wire logic       clr,
   input  wire logic       smp,
   input  wire logic [3:0] idx,
   output int              cnt,
   output logic            order_ok
);
   logic [3:0] last_q;

   always @(posedge mclk) begin
      if (clr) begin
         cnt <= 0;
         order_ok <= 1'b1;
      end else if (smp) begin
         if (cnt > 0 && idx <= last_q)
            order_ok <= 1'b0;
         last_q <= idx;
         cnt <= cnt + 1;
      end
   end
endmodule : cssq_cell_model

// ==== tb_top.sv ====
// Bench for the sequencer: runs each scan kind and times it in us.
// Assumes the package and the cell model are compiled first.
`timescale 1ns/1ns
module tb_top;
   import cssq_pkg::*;
   localparam int US = 4;
   // Wire scan total with four cells connected
   localparam int WIRE_4_US = 2942;
   logic            mclk, sys_rst, start, clr;
   cssq_kind_t      kind;
   logic [13:0]     cell_en;
   logic [2:0]      cav;
   cssq_gpio2_cfg_t cfg;
   logic            busy, done, csp, aux, mta, mps, g_out, g_oe, ord;
   logic [3:0]      cidx;
   logic [2:0]      pcnt;
   logic            aux_s, mta_s;
   int              mismatches, cmp_count, cyc, t0, dur, ncell;
   int              first_c, c14, hi_len, lo_len, hi_run, lo_run;
   int              mrun, mlo;

   cssq_sequencer #(.US_CYCLES(US)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .start(start), .scan_kind(kind),
      .cell_enable(cell_en), .cell_average_count(cav), .gpio2_cfg(cfg),
      .busy(busy), .done(done), .cell_sample_pulse(csp),
      .cell_index(cidx), .aux_sample_pulse(aux), .mux_test_active(mta),
      .mux_test_phase_select(mps), .pass_count_q(pcnt), .gpio2_out(g_out),
      .gpio2_oe(g_oe)
   );
   cssq_cell_model i_model (
      .mclk(mclk), .clr(clr), .smp(csp), .idx(cidx), .cnt(ncell),
      .order_ok(ord)
   );

   // Timing monitor, cleared at each take edge
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (clr) begin
         first_c <= -1;
         {c14, hi_len, lo_len, hi_run, lo_run, mrun, mlo} <= '0;
         {aux_s, mta_s} <= 2'b00;
      end else begin
         if (csp === 1'b1 && first_c < 0)
            first_c <= cyc - t0;
         if (csp === 1'b1 && ncell == 13)
            c14 <= cyc - t0;
         if (aux === 1'b1)
            aux_s <= 1'b1;
         if (mta === 1'b1)
            mta_s <= 1'b1;
         mrun <= (mps === 1'b0) ? mrun + 1 : 0;
         if (mps === 1'b1 && mrun > 0)
            mlo <= mrun;
         if (g_out === 1'b1) begin
            hi_run <= hi_run + 1;
            lo_run <= 0;
            if (lo_run > 0)
               lo_len <= lo_run;
         end else begin
            hi_run <= 0;
            if (hi_run > 0)
               hi_len <= hi_run;
            lo_run <= (hi_len > 0 || hi_run > 0) ? lo_run + 1 : 0;
         end
      end
   end

   task automatic chk(string nm, logic [31:0] seen, int exp, int tol);
      cmp_count++;
      if ((seen >= exp - tol && seen <= exp + tol) !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %s exp %0d seen %0d", nm, exp, seen);
      end
   endtask : chk

   function automatic int tl(int e);
      return e / 25 + 2;
   endfunction : tl

   task automatic run(cssq_kind_t k, logic [13:0] m, logic [2:0] a,
                      logic [2:0] c);
      @(posedge mclk);
      #1;
      kind = k;
      cell_en = m;
      cav = a;
      cfg = c;
      clr = 1'b1;
      start = 1'b1;
      @(posedge mclk);
      t0 = cyc;
      #1;
      start = 1'b0;
      clr = 1'b0;
      chk("busy", busy, 1, 0);
      for (int i = 0; i < 90000 && done !== 1'b1; i++)
         @(posedge mclk);
      if (done !== 1'b1) begin
         mismatches++;
         $display("[FAIL] scan end exp done seen timeout");
      end
      dur = (cyc - t0) / US;
      @(posedge mclk);
      #1;
      chk("idle after done", busy, 0, 0);
      chk("done once", done, 0, 0);
   endtask : run

   task automatic test_done;
      $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial begin
      #400000;
      mismatches++;
      test_done();
   end

   initial begin
      {sys_rst, clr, start} = 3'b110;
      kind = CSSQ_SCAN_VOLT;
      {cell_en, cav, cfg} = '0;
      {mismatches, cmp_count, cyc, t0} = '0;
      repeat (10) @(posedge mclk);
      #1 sys_rst = 1'b0;
      run(CSSQ_SCAN_VOLT, 14'h3fff, 3'h0, 3'h7);
      chk("volt14 us", dur, VOLT_14_US, tl(VOLT_14_US));
      chk("volt14 cells", ncell, 14, 0);
      chk("cell order", ord, 1, 0);
      chk("aux volt", aux_s, 1, 0);
      chk("gpio2 oe on", g_oe, 1, 0);
      chk("gpio2 high us", hi_len / US, ADC_HIGH_US, tl(ADC_HIGH_US));
      run(CSSQ_SCAN_VOLT, 14'h000f, 3'h6, 3'h3);
      chk("volt4 us", dur, VOLT_4_US, tl(VOLT_4_US));
      chk("cav6 one pass", pcnt, 0, 0);
      chk("volt4 cells", ncell, 4, 0);
      chk("gpio2 oe off", g_oe, 0, 0);
      chk("gpio2 idle", hi_len, 0, 0);
      run(CSSQ_SCAN_VOLT, 14'h3fff, 3'h1, 3'h7);
      chk("avg2 us", dur, 2 * VOLT_14_US + AVG_GAP_US, 50);
      chk("gpio2 low us", lo_len / US, ADC_LOW_US, tl(ADC_LOW_US));
      run(CSSQ_SCAN_VOLT, 14'h3fff, 3'h2, 3'h0);
      chk("avg4 us", dur, 4 * VOLT_14_US + 3 * AVG_GAP_US, 100);
      chk("avg4 last pass", pcnt, 4 - 1, 0);
      run(CSSQ_SCAN_TEMP, 14'h000f, 3'h0, 3'h0);
      chk("temp4 us", dur, TEMP_SCAN_US, tl(TEMP_SCAN_US));
      run(CSSQ_SCAN_WIRE, 14'h000f, 3'h0, 3'h0);
      chk("wire4 us", dur, WIRE_4_US, tl(WIRE_4_US));
      chk("wire4 cells", ncell, 4, 0);
      chk("aux wire", aux_s, 1, 0);
      run(CSSQ_SCAN_ALL, 14'h3fff, 3'h0, 3'h0);
      chk("all us", dur, ALL_14_US, tl(ALL_14_US));
      chk("aux all", aux_s, 1, 0);
      run(CSSQ_SCAN_MUX, 14'h3fff, 3'h0, 3'h0);
      chk("mux us", dur, MUX_END_US, tl(MUX_END_US));
      chk("cell1 us", first_c / US, MUX_CELL1_US, 2);
      chk("cell14 us", c14 / US, MUX_CELL14_US, 4);
      chk("mux test", mta_s, 1, 0);
      chk("phase us", mlo / US, MUX_ITER_US - MUX_PHASE_US, 21);
      test_done();
   end
endmodule : tb_top
